// ===== hw/dds_cfg_params.svh
// Register offsets, field positions, reset values and timing counts of the host port block.
`ifndef DDS_CFG_PARAMS_SVH
`define DDS_CFG_PARAMS_SVH

`define ADDR_UPD_3            6'h16
`define ADDR_UPD_2            6'h17
`define ADDR_UPD_1            6'h18
`define ADDR_UPD_0            6'h19
`define ADDR_PWR_DOWN         6'h1D
`define ADDR_CLK_MULT         6'h1E
`define ADDR_UPD_MODE         6'h1F
`define ADDR_BYPASS           6'h20
`define RST_UPD_3             8'h00
`define RST_UPD_2             8'h00
`define RST_UPD_1             8'h00
`define RST_UPD_0             8'h40
`define RST_PWR_DOWN          8'h00
`define RST_CLK_MULT          8'h04
`define RST_UPD_MODE          8'h01
`define RST_BYPASS            8'h00
`define MULT_LSB              0
`define MULT_MSB              4
`define PLL_RANGE_BIT         6
`define PLL_BYPASS_BIT        5
`define UPD_INTERNAL_BIT      0
`define BYP_SINC_BIT          6
`define BYP_MULT_BIT          5
`define PD_FIRST_BIT          0
`define PD_COUNT              4
`define UPD_HIGH_CYCLES       4'h8
`define REF_SEEN_CYCLES       8'h10
`define WR_SPACING_PS         10500
`define CLK_PERIOD_PS         5000
`define WR_SPACING_CYCLES     ((`WR_SPACING_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ===== hw/dds_cfg_pkg.sv
// Types shared by the host port block.
`default_nettype none
package dds_cfg_pkg;
    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_HIGH = 2'b01
    } xfer_state_t;
    typedef logic [7:0] reg_byte_t;
endpackage : dds_cfg_pkg
`default_nettype wire

// ===== hw/dds_host_port_cfg.sv
// Host programming port, buffer memory, update transfer and clock/power configuration.
`default_nettype none
`include "dds_cfg_params.svh"
module dds_host_port_cfg #(
    parameter int NUM_REGS = 64
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       port_parallel_strap_in,
    input  wire logic       differential_input_select_in,
    input  wire logic       reference_clock_alive_in,
    input  wire logic [5:0] addr_in,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe_out,
    input  wire logic       wr_n_in,
    input  wire logic       rd_n_in,
    input  wire logic       register_transfer_pin_in,
    output logic            register_transfer_pin_out,
    output logic            register_transfer_pin_oe_out,
    input  wire logic       ser_wr_in,
    input  wire logic [5:0] ser_addr_in,
    input  wire logic [7:0] ser_data_in,
    output logic      [7:0] ser_rd_data_out,
    output logic      [4:0] mult_factor_out,
    output logic            pll_engaged_out,
    output logic            pll_range_out,
    output logic            diff_ref_enable_out,
    output logic      [3:0] stage_power_down_bits_out,
    output logic            full_power_down_out,
    output logic            bypass_inv_sinc_out,
    output logic            bypass_digital_mult_out,
    output logic            parallel_mode_out,
    output logic            transfer_strobe_out
);
    // Strobe, update, reference, strap and select pins pass two flip-flops before any logic sees them.
    logic wr_n_s;
    logic rd_n_s;
    logic upd_pin_s;
    logic ref_alive_s;
    logic strap_s;
    logic diff_s;

    dds_sync2 u_sync_wr (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(wr_n_in), .sync_out(wr_n_s));
    dds_sync2 u_sync_rd (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(rd_n_in), .sync_out(rd_n_s));
    dds_sync2 u_sync_upd (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(register_transfer_pin_in), .sync_out(upd_pin_s));
    dds_sync2 u_sync_ref (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(reference_clock_alive_in), .sync_out(ref_alive_s));
    dds_sync2 u_sync_strap (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(port_parallel_strap_in), .sync_out(strap_s));
    dds_sync2 u_sync_diff (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(differential_input_select_in), .sync_out(diff_s));

    // Buffer memory written by the host and the active banks that steer the device.
    dds_cfg_pkg::reg_byte_t buf_r    [NUM_REGS];
    dds_cfg_pkg::reg_byte_t buf_nxt  [NUM_REGS];
    dds_cfg_pkg::reg_byte_t act_r    [NUM_REGS];
    dds_cfg_pkg::reg_byte_t act_nxt  [NUM_REGS];

    logic        wr_n_d_r;
    logic        wr_n_d_nxt;
    logic        rd_n_d_r;
    logic        rd_n_d_nxt;
    logic        upd_d_r;
    logic        upd_d_nxt;
    logic [1:0]  wr_gap_r;
    logic [1:0]  wr_gap_nxt;
    logic [5:0]  addr_hold_r;
    logic [5:0]  addr_hold_nxt;
    logic [7:0]  data_hold_r;
    logic [7:0]  data_hold_nxt;
    logic [1:0]  hold_age_r;
    logic [1:0]  hold_age_nxt;
    logic [7:0]  rd_data_r;
    logic [7:0]  rd_data_nxt;
    logic        rd_oe_r;
    logic        rd_oe_nxt;
    logic [7:0]  ser_rd_r;
    logic [7:0]  ser_rd_nxt;
    logic [32:0] int_cnt_r;
    logic [32:0] int_cnt_nxt;
    logic [3:0]  hi_cnt_r;
    logic [3:0]  hi_cnt_nxt;
    logic        pin_out_r;
    logic        pin_out_nxt;
    logic        xfer_r;
    logic        xfer_nxt;
    logic        par_mode_r;
    logic        par_mode_nxt;
    logic [1:0]  strap_caught_r;
    logic [1:0]  strap_caught_nxt;
    dds_cfg_pkg::xfer_state_t st_r;
    dds_cfg_pkg::xfer_state_t st_nxt;

    logic        wr_fall;
    logic        rd_fall;
    logic        ext_edge;
    logic        internal_mode_r_q;
    logic        internal_mode;
    logic        int_fire;
    logic        do_xfer;
    logic [32:0] interval;

    // Address and data are sampled a few cycles into the strobe so they have settled.
    assign wr_fall       = wr_n_d_r & ~wr_n_s;
    assign rd_fall       = rd_n_d_r & ~rd_n_s;
    assign ext_edge      = upd_pin_s & ~upd_d_r;
    assign internal_mode = act_r[`ADDR_UPD_MODE][`UPD_INTERNAL_BIT];
    // The interval is (N + 1) * 2 cycles; a 33-bit count avoids overflow at N = all ones.
    assign interval      = {act_r[`ADDR_UPD_3], act_r[`ADDR_UPD_2],
                            act_r[`ADDR_UPD_1], act_r[`ADDR_UPD_0], 1'b1} + 33'h1;
    assign int_fire      = internal_mode && (int_cnt_r >= interval - 33'h1);
    // No transfer until the reference clock is seen running.
    assign do_xfer       = ref_alive_s && (internal_mode ? int_fire : ext_edge);

    // Host port, buffer, transfer sequencing and pin drive.
    always_comb begin
        buf_nxt          = buf_r;
        act_nxt          = act_r;
        wr_n_d_nxt       = wr_n_s;
        rd_n_d_nxt       = rd_n_s;
        upd_d_nxt        = upd_pin_s;
        wr_gap_nxt       = (wr_gap_r != 2'h0) ? wr_gap_r - 2'h1 : 2'h0;
        addr_hold_nxt    = addr_hold_r;
        data_hold_nxt    = data_hold_r;
        hold_age_nxt     = hold_age_r;
        rd_data_nxt      = rd_data_r;
        rd_oe_nxt        = rd_oe_r;
        ser_rd_nxt       = buf_r[ser_addr_in];
        int_cnt_nxt      = int_cnt_r;
        hi_cnt_nxt       = hi_cnt_r;
        pin_out_nxt      = pin_out_r;
        xfer_nxt         = 1'b0;
        st_nxt           = st_r;
        // The strap is taken on the third edge after reset, once its synchroniser has filled.
        strap_caught_nxt = (strap_caught_r == 2'h3) ? 2'h3 : strap_caught_r + 2'h1;
        par_mode_nxt     = (strap_caught_r == 2'h2) ? strap_s : par_mode_r;
        // Parallel writes, one byte each, honouring the minimum write spacing.
        if (par_mode_r && wr_fall && (wr_gap_r == 2'h0)) begin
            addr_hold_nxt = addr_in;
            data_hold_nxt = data_in;
            hold_age_nxt  = 2'h1;
            wr_gap_nxt    = 2'(`WR_SPACING_CYCLES);
        end else if (hold_age_r != 2'h0) begin
            hold_age_nxt = 2'h0;
            buf_nxt[addr_hold_r] = data_hold_r;
        end
        // Serial writes arrive already framed from the serial shifter.
        if (!par_mode_r && ser_wr_in) begin
            buf_nxt[ser_addr_in] = ser_data_in;
        end
        // Readback drives the data lines while the read strobe is low.
        if (par_mode_r && rd_fall) begin
            rd_data_nxt = buf_r[addr_in];
            rd_oe_nxt   = 1'b1;
        end else if (rd_n_s) begin
            rd_oe_nxt = 1'b0;
        end
        // Internal interval counter.
        if (internal_mode && ref_alive_s) begin
            int_cnt_nxt = int_fire ? 33'h0 : int_cnt_r + 33'h1;
        end else begin
            int_cnt_nxt = 33'h0;
        end
        // Copy the whole buffer into the active banks in one cycle.
        if (do_xfer) begin
            act_nxt  = buf_r;
            xfer_nxt = 1'b1;
        end
        // Internal mode drives the transfer pin high for a fixed time.
        case (st_r)
            dds_cfg_pkg::XFER_IDLE: begin
                pin_out_nxt = 1'b0;
                if (internal_mode && int_fire && ref_alive_s) begin
                    st_nxt      = dds_cfg_pkg::XFER_HIGH;
                    pin_out_nxt = 1'b1;
                    hi_cnt_nxt  = `UPD_HIGH_CYCLES - 4'h1;
                end
            end
            dds_cfg_pkg::XFER_HIGH: begin
                if (hi_cnt_r == 4'h0) begin
                    st_nxt      = dds_cfg_pkg::XFER_IDLE;
                    pin_out_nxt = 1'b0;
                end else begin
                    hi_cnt_nxt  = hi_cnt_r - 4'h1;
                end
            end
            default: begin
                st_nxt      = dds_cfg_pkg::XFER_IDLE;
                pin_out_nxt = 1'b0;
            end
        endcase
    end

    // Master reset loads every default into both buffer and banks.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                buf_r[i] <= 8'h00;
                act_r[i] <= 8'h00;
            end
            buf_r[`ADDR_UPD_3]    <= `RST_UPD_3;
            buf_r[`ADDR_UPD_2]    <= `RST_UPD_2;
            buf_r[`ADDR_UPD_1]    <= `RST_UPD_1;
            buf_r[`ADDR_UPD_0]    <= `RST_UPD_0;
            buf_r[`ADDR_PWR_DOWN] <= `RST_PWR_DOWN;
            buf_r[`ADDR_CLK_MULT] <= `RST_CLK_MULT;
            buf_r[`ADDR_UPD_MODE] <= `RST_UPD_MODE;
            buf_r[`ADDR_BYPASS]   <= `RST_BYPASS;
            act_r[`ADDR_UPD_3]    <= `RST_UPD_3;
            act_r[`ADDR_UPD_2]    <= `RST_UPD_2;
            act_r[`ADDR_UPD_1]    <= `RST_UPD_1;
            act_r[`ADDR_UPD_0]    <= `RST_UPD_0;
            act_r[`ADDR_PWR_DOWN] <= `RST_PWR_DOWN;
            act_r[`ADDR_CLK_MULT] <= `RST_CLK_MULT;
            act_r[`ADDR_UPD_MODE] <= `RST_UPD_MODE;
            act_r[`ADDR_BYPASS]   <= `RST_BYPASS;
            wr_n_d_r       <= 1'b0; // Matches the synchroniser, so no false edge.
            rd_n_d_r       <= 1'b0;
            upd_d_r        <= 1'b0;
            wr_gap_r       <= 2'h0;
            addr_hold_r    <= 6'h00;
            data_hold_r    <= 8'h00;
            hold_age_r     <= 2'h0;
            rd_data_r      <= 8'h00;
            rd_oe_r        <= 1'b0;
            ser_rd_r       <= 8'h00;
            int_cnt_r      <= 33'h0;
            hi_cnt_r       <= 4'h0;
            pin_out_r      <= 1'b0;
            xfer_r         <= 1'b0;
            st_r           <= dds_cfg_pkg::XFER_IDLE;
            par_mode_r     <= 1'b0;
            strap_caught_r <= 2'h0;
        end else begin
            buf_r          <= buf_nxt;
            act_r          <= act_nxt;
            wr_n_d_r       <= wr_n_d_nxt;
            rd_n_d_r       <= rd_n_d_nxt;
            upd_d_r        <= upd_d_nxt;
            wr_gap_r       <= wr_gap_nxt;
            addr_hold_r    <= addr_hold_nxt;
            data_hold_r    <= data_hold_nxt;
            hold_age_r     <= hold_age_nxt;
            rd_data_r      <= rd_data_nxt;
            rd_oe_r        <= rd_oe_nxt;
            ser_rd_r       <= ser_rd_nxt;
            int_cnt_r      <= int_cnt_nxt;
            hi_cnt_r       <= hi_cnt_nxt;
            pin_out_r      <= pin_out_nxt;
            xfer_r         <= xfer_nxt;
            st_r           <= st_nxt;
            par_mode_r     <= par_mode_nxt;
            strap_caught_r <= strap_caught_nxt;
        end
    end

    // Configuration outputs are decoded from the active banks and registered; the reference input select comes from its pin.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mult_factor_out           <= 5'h04;
            pll_engaged_out           <= 1'b1;
            pll_range_out             <= 1'b0;
            diff_ref_enable_out       <= 1'b0;
            stage_power_down_bits_out <= 4'h0;
            full_power_down_out       <= 1'b0;
            bypass_inv_sinc_out       <= 1'b0;
            bypass_digital_mult_out   <= 1'b0;
        end else begin
            mult_factor_out <= act_r[`ADDR_CLK_MULT][`MULT_MSB:`MULT_LSB];
            // Clock source mux select: multiplier output unless bypassed.
            pll_engaged_out <= ~act_r[`ADDR_CLK_MULT][`PLL_BYPASS_BIT];
            pll_range_out   <= act_r[`ADDR_CLK_MULT][`PLL_RANGE_BIT];
            diff_ref_enable_out <= diff_s;
            stage_power_down_bits_out <=
                act_r[`ADDR_PWR_DOWN][`PD_FIRST_BIT +: `PD_COUNT];
            full_power_down_out <= &act_r[`ADDR_PWR_DOWN][`PD_FIRST_BIT +: `PD_COUNT];
            bypass_inv_sinc_out     <= act_r[`ADDR_BYPASS][`BYP_SINC_BIT];
            bypass_digital_mult_out <= act_r[`ADDR_BYPASS][`BYP_MULT_BIT];
        end
    end

    // Pins and status outputs come straight from flip-flops.
    assign data_out                     = rd_data_r;
    assign data_oe_out                  = rd_oe_r;
    assign ser_rd_data_out              = ser_rd_r;
    assign register_transfer_pin_out    = pin_out_r;
    assign register_transfer_pin_oe_out = internal_mode_r_q;
    assign parallel_mode_out            = par_mode_r;
    assign transfer_strobe_out          = xfer_r;

    // Direction of the transfer pin follows the active update mode bit.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            internal_mode_r_q <= 1'b1;
        end else begin
            internal_mode_r_q <= internal_mode;
        end
    end
endmodule : dds_host_port_cfg
`default_nettype wire

// ===== hw/dds_sync2.sv
// Two flip-flop synchroniser for one level.
`default_nettype none
module dds_sync2 (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_r;

    // The first stage is seen only by the second one.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : dds_sync2
`default_nettype wire

// ===== test/dds_host_model.sv
// Host processor model on the byte-wide parallel port.
`default_nettype none
module dds_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] dev_data_in,
    input  wire logic       dev_oe_in,
    output var  logic [5:0] addr_out = 6'h00,
    output logic      [7:0] bus_out,
    output var  logic       wr_n_out = 1'b1,
    output var  logic       rd_n_out = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv_r = 8'h00;
    logic       drv_oe_r = 1'b0;
    logic [7:0] last_r = 8'h00;
    // Released lines have no pull, so they show the inverse of their last level.
    assign bus_out = dev_oe_in ? dev_data_in : (drv_oe_r ? drv_r : ~last_r);
    always @(posedge clk_in) last_r <= bus_out;
    // One byte per write; the idle tail keeps accepted writes well apart.
    task automatic write_byte(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        drv_r = d;
        drv_oe_r = 1'b1;
        wr_n_out = 1'b0;
        repeat (2) @(negedge clk_in);
        wr_n_out = 1'b1;
        repeat (2) @(negedge clk_in);
        drv_oe_r = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask : write_byte
    // Reads are slow debug accesses that wait for the device to drive the lines.
    task automatic read_byte(input logic [5:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(negedge clk_in);
        addr_out = a;
        rd_n_out = 1'b0;
        for (n = 0; n < 10 && dev_oe_in !== 1'b1; n++) @(negedge clk_in);
        ok = (n < 10);
        d = dev_data_in;
        rd_n_out = 1'b1;
        for (n = 0; n < 10 && dev_oe_in !== 1'b0; n++) @(negedge clk_in);
        ok = ok && (n < 10);
    endtask : read_byte
endmodule : dds_host_model
`default_nettype wire

// ===== test/dds_host_port_cfg_monitor.sv
// Port-level checker for the host port and configuration block.
`default_nettype none
module dds_host_port_cfg_monitor (
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic       port_parallel_strap_in,
    input wire logic       differential_input_select_in,
    input wire logic       reference_clock_alive_in,
    input wire logic       rd_n_in,
    input wire logic       data_oe_out,
    input wire logic       register_transfer_pin_out,
    input wire logic       register_transfer_pin_oe_out,
    input wire logic [4:0] mult_factor_out,
    input wire logic       pll_engaged_out,
    input wire logic       pll_range_out,
    input wire logic       diff_ref_enable_out,
    input wire logic [3:0] stage_power_down_bits_out,
    input wire logic       full_power_down_out,
    input wire logic       bypass_inv_sinc_out,
    input wire logic       bypass_digital_mult_out,
    input wire logic       parallel_mode_out,
    input wire logic       transfer_strobe_out
);
    // Every level the active bank drives except full power-down and the transfer pin direction, so that any change can be tied to a transfer.
    logic [12:0] active;
    assign active = {mult_factor_out, pll_engaged_out, pll_range_out,
        stage_power_down_bits_out, bypass_inv_sinc_out, bypass_digital_mult_out};
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // The strobe leads the bank update by one cycle; the check also allows up to two cycles ahead or one behind.
    AST_ACTIVE_ON_TRANSFER: assert property ($changed(active) |->
        (transfer_strobe_out || $past(transfer_strobe_out) || $past(transfer_strobe_out, 2))
        or ##1 transfer_strobe_out) else $error("active bank changed without a transfer");
    AST_FULL_POWER_DOWN: assert property (full_power_down_out == &stage_power_down_bits_out)
        else $error("full power-down does not match the stage bits");
    AST_PULSE_EIGHT: assert property (
        $rose(register_transfer_pin_out) && register_transfer_pin_oe_out |->
        (register_transfer_pin_out || !register_transfer_pin_oe_out)[*8] ##1
        !(register_transfer_pin_out && register_transfer_pin_oe_out))
        else $error("update pulse is not eight cycles high");
    AST_PULSE_WITH_STROBE: assert property (
        $rose(register_transfer_pin_out) && register_transfer_pin_oe_out |-> transfer_strobe_out)
        else $error("update pulse without a transfer strobe");
    AST_NO_REF_NO_TRANSFER: assert property (!reference_clock_alive_in[*6] |->
        !transfer_strobe_out) else $error("transfer without a reference clock");
    AST_STRAP_MODE: assert property ($fell(sys_rst_in) ##0 $stable(port_parallel_strap_in)[*4]
        |=> (parallel_mode_out == port_parallel_strap_in)[*4]) else $error("port mode wrong");
    AST_READ_RELEASE: assert property (rd_n_in[*5] |-> !data_oe_out)
        else $error("data lines driven without a read");
    AST_DIFF_SELECT: assert property ($stable(differential_input_select_in)[*5] |->
        diff_ref_enable_out == differential_input_select_in) else $error("reference input wrong");
    cover property (transfer_strobe_out && register_transfer_pin_oe_out);
    cover property (full_power_down_out);
    cover property ($rose(data_oe_out));
endmodule : dds_host_port_cfg_monitor
bind dds_host_port_cfg dds_host_port_cfg_monitor mon (.clk_in, .sys_rst_in,
    .port_parallel_strap_in, .differential_input_select_in, .reference_clock_alive_in,
    .rd_n_in, .data_oe_out, .register_transfer_pin_out, .register_transfer_pin_oe_out,
    .mult_factor_out, .pll_engaged_out, .pll_range_out, .diff_ref_enable_out,
    .stage_power_down_bits_out, .full_power_down_out, .bypass_inv_sinc_out,
    .bypass_digital_mult_out, .parallel_mode_out, .transfer_strobe_out);
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench: reset and timing cases, then a table of register writes, then interval and mode cases.
`default_nettype none
`include "dds_cfg_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [5:0] a; logic [7:0] d; logic [12:0] e;} row_t;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, port_parallel_strap_in = 1'b1;
    logic differential_input_select_in = 1'b0, reference_clock_alive_in = 1'b0;
    logic register_transfer_pin_in = 1'b0, ser_wr_in = 1'b0;
    logic [5:0] ser_addr_in = 6'h00, addr_in;
    logic [7:0] ser_data_in = 8'h00, data_in, data_out, ser_rd_data_out;
    logic data_oe_out, wr_n_in, rd_n_in, register_transfer_pin_out, pll_engaged_out;
    logic register_transfer_pin_oe_out, pll_range_out, diff_ref_enable_out;
    logic full_power_down_out, bypass_inv_sinc_out, bypass_digital_mult_out;
    logic parallel_mode_out, transfer_strobe_out;
    logic [4:0] mult_factor_out;
    logic [3:0] stage_power_down_bits_out;
    wire  [12:0] active = {mult_factor_out, pll_engaged_out, pll_range_out,
        stage_power_down_bits_out, bypass_inv_sinc_out, bypass_digital_mult_out};
    int errors = 0;
    int checked = 0;
    // Address, byte, and active outputs expected after the next transfer.
    row_t rows [7] = '{'{`ADDR_CLK_MULT, 8'h54, 13'h14C0}, '{`ADDR_CLK_MULT, 8'h2C, 13'h0C00},
        '{`ADDR_PWR_DOWN, 8'h05, 13'h0C14}, '{`ADDR_PWR_DOWN, 8'h0F, 13'h0C3C},
        '{`ADDR_BYPASS, 8'h40, 13'h0C3E}, '{`ADDR_BYPASS, 8'h20, 13'h0C3D},
        '{`ADDR_PWR_DOWN, 8'h00, 13'h0C01}};
    always #2.5 clk_in = ~clk_in;
    dds_host_port_cfg dut (.*);
    dds_host_model host (.clk_in, .dev_data_in(data_out), .dev_oe_in(data_oe_out),
        .addr_out(addr_in), .bus_out(data_in), .wr_n_out(wr_n_in), .rd_n_out(rd_n_in));
    // Comparison of design values; case inequality keeps unknowns from matching.
    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check_val
    task automatic check_cnt(input string name, input int exp, input int got);
        checked++;
        if (got != exp) begin
            errors++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
        end
    endtask : check_cnt
    task automatic complete_run();
        $display("comparisons %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // Bounded wait for the next strobe; cyc is the distance from the call's cycle.
    task automatic wait_strobe(input int limit, output int cyc);
        @(negedge clk_in);
        for (cyc = 1; transfer_strobe_out !== 1'b1; cyc++) begin
            if (cyc > limit) begin
                errors++;
                $display("unexpected transfer strobe: expected pulse, seen none");
                complete_run();
            end
            @(negedge clk_in);
        end
    endtask : wait_strobe
    task automatic count_strobes(input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(negedge clk_in);
            n += (transfer_strobe_out === 1'b1);
        end
    endtask : count_strobes
    // Write, read back, then compare the active outputs after the next transfer.
    task automatic put(input row_t r);
        logic [7:0] rd;
        logic       ok;
        int         cyc;
        host.write_byte(r.a, r.d);
        host.read_byte(r.a, rd, ok);
        check_val("readback", {7'h00, 1'b1, r.d}, {7'h00, ok, rd});
        wait_strobe(400, cyc);
        repeat (3) @(negedge clk_in);
        check_val("active", {2'b00, &r.e[5:2], r.e}, {2'b00, full_power_down_out, active});
    endtask : put
    // Main sequence; the second reset switches the port type strap to serial.
    initial begin
        int n;
        int cyc;
        repeat (10) @(negedge clk_in);
        check_val("reset bank", 16'h2404, {active, register_transfer_pin_oe_out, data_oe_out,
            transfer_strobe_out});
        check_val("reset flags", 16'h0000, {12'h000, parallel_mode_out, diff_ref_enable_out,
            full_power_down_out, register_transfer_pin_out});
        repeat (10) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (10) @(negedge clk_in);
        check_val("parallel mode", 16'h0001, {15'h0000, parallel_mode_out});
        count_strobes(300, n);
        check_cnt("transfers without reference", 0, n);
        reference_clock_alive_in = 1'b1;
        wait_strobe(400, cyc);
        wait_strobe(400, cyc);
        check_cnt("default interval", 130, cyc);
        for (n = 0; n < 20 && register_transfer_pin_out === 1'b1; n++) @(negedge clk_in);
        check_cnt("update pulse length", 8, n);
        for (int k = 4; k <= 20; k++) put('{`ADDR_CLK_MULT, 8'(k), {5'(k), 8'h80}});
        foreach (rows[i]) put(rows[i]);
        host.write_byte(`ADDR_UPD_0, 8'h05);
        repeat (3) wait_strobe(400, cyc);
        check_cnt("short interval", 12, cyc);
        host.write_byte(`ADDR_UPD_MODE, 8'h00);
        wait_strobe(400, cyc);
        host.write_byte(`ADDR_PWR_DOWN, 8'h03);
        count_strobes(200, n);
        check_cnt("transfers while external", 0, n);
        check_val("external hold", 16'h0C01, {register_transfer_pin_oe_out, 2'b00, active});
        register_transfer_pin_in = 1'b1;
        wait_strobe(20, cyc);
        register_transfer_pin_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check_val("external transfer", 16'h0C0D, {3'h0, active});
        differential_input_select_in = 1'b1;
        repeat (6) @(negedge clk_in);
        check_val("differential select", 16'h0001, {15'h0000, diff_ref_enable_out});
        sys_rst_in = 1'b1;
        port_parallel_strap_in = 1'b0;
        repeat (20) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (10) @(negedge clk_in);
        check_val("serial mode", 16'h0000, {15'h0000, parallel_mode_out});
        ser_addr_in = `ADDR_PWR_DOWN;
        ser_data_in = 8'h0A;
        ser_wr_in = 1'b1;
        @(negedge clk_in);
        ser_wr_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check_val("serial readback", 16'h000A, {8'h00, ser_rd_data_out});
        host.write_byte(`ADDR_BYPASS, 8'h60);
        ser_addr_in = `ADDR_BYPASS;
        wait_strobe(400, cyc);
        repeat (3) @(negedge clk_in);
        check_val("parallel write ignored", 16'h0000, {8'h00, ser_rd_data_out});
        check_val("serial transfer", 16'h04A8, {3'h0, active});
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
